// ### src/cff_exec.sv
// Execution unit for calls, returns, sleep, flag operations and block move.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cff_consts.svh"
module cff_exec (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic wake_i,
  output logic busy_o,
  output logic sleep_o
);
  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic cff_pkg::cff_op_t op_decode(input logic [15:0] w, output logic bad);
    bad = 1'b0;
    case (w[15:8])
      `CFF_OPC_NOP: op_decode = cff_pkg::CFF_OP_NOP;
      `CFF_OPC_SLEEP: op_decode = cff_pkg::CFF_OP_SLEEP;
      `CFF_OPC_STC: op_decode = cff_pkg::CFF_OP_STC;
      `CFF_OPC_LDCR: op_decode = cff_pkg::CFF_OP_LDCR;
      `CFF_OPC_ORC: op_decode = cff_pkg::CFF_OP_ORC;
      `CFF_OPC_XORC: op_decode = cff_pkg::CFF_OP_XORC;
      `CFF_OPC_ANDC: op_decode = cff_pkg::CFF_OP_ANDC;
      `CFF_OPC_LDCI: op_decode = cff_pkg::CFF_OP_LDCI;
      `CFF_OPC_ADDW: op_decode = cff_pkg::CFF_OP_ADDW;
      `CFF_OPC_ADDX: op_decode = cff_pkg::CFF_OP_ADDX;
      `CFF_OPC_DEC_ADJ: op_decode = cff_pkg::CFF_OP_DEC_ADJ;
      `CFF_OPC_DIV: op_decode = cff_pkg::CFF_OP_DIV;
      `CFF_OPC_RTS: op_decode = cff_pkg::CFF_OP_RTS;
      `CFF_OPC_XRET: op_decode = cff_pkg::CFF_OP_XRET;
      `CFF_OPC_CALL: op_decode = cff_pkg::CFF_OP_CALL;
      `CFF_OPC_BMOVE: begin
        // The block move owns only the half of this first byte with bit 7 clear.
        op_decode = w[7] ? cff_pkg::CFF_OP_NOP : cff_pkg::CFF_OP_BMOVE;
        bad = w[7];
      end
      `CFF_OPC_MOVSTK: begin
        // Stack push and pop are plain moves here, which this unit does not run.
        op_decode = cff_pkg::CFF_OP_NOP;
        bad = 1'b1;
      end
      default: begin
        op_decode = cff_pkg::CFF_OP_NOP;
        bad = 1'b1;
      end
    endcase
  endfunction : op_decode

  function automatic logic [11:0] op_len(input cff_pkg::cff_op_t op, input logic [7:0] n);
    case (op)
      cff_pkg::CFF_OP_CALL: op_len = `CFF_LEN_CALL;
      cff_pkg::CFF_OP_RTS: op_len = `CFF_LEN_RET;
      cff_pkg::CFF_OP_XRET: op_len = `CFF_LEN_XRET;
      cff_pkg::CFF_OP_BMOVE: op_len = {2'b00, n, 2'b00} + `CFF_MOVE_BASE;
      default: op_len = `CFF_LEN_SHORT;
    endcase
  endfunction : op_len

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cff_pkg::cff_regs_t r;
  cff_pkg::cff_regs_t n;
  logic last;
  logic bad;
  cff_pkg::cff_op_t dop;
  logic [16:0] sum17;
  logic [12:0] sum12;
  logic [8:0] sum9;
  logic [4:0] sum4;
  logic [7:0] adj;
  logic [8:0] daa9;
  logic [15:0] quo;
  logic [15:0] rem;

  always_comb begin
    n = r;
    last = 1'b0;
    bad = 1'b0;
    dop = cff_pkg::CFF_OP_NOP;
    sum17 = {1'b0, r.work} + {1'b0, r.opnd};
    sum12 = {1'b0, r.work[11:0]} + {1'b0, r.opnd[11:0]};
    sum9 = {1'b0, r.work[7:0]} + {1'b0, r.opnd[7:0]} + {8'h00, r.flags[`CFF_FL_C]};
    sum4 = {1'b0, r.work[3:0]} + {1'b0, r.opnd[3:0]} + {4'h0, r.flags[`CFF_FL_C]};
    adj[3:0] = (r.flags[`CFF_FL_H] || (r.work[3:0] > 4'h9)) ? 4'h6 : 4'h0;
    adj[7:4] = (r.flags[`CFF_FL_C] || (r.work[7:0] > 8'h99)) ? 4'h6 : 4'h0;
    daa9 = {1'b0, r.work[7:0]} + {1'b0, adj};
    quo = (r.opnd[7:0] == 8'h00) ? r.work : r.work / {8'h00, r.opnd[7:0]};
    rem = (r.opnd[7:0] == 8'h00) ? 16'h0000 : r.work % {8'h00, r.opnd[7:0]};
    n.mem_req = 1'b0;
    n.mem_we = 1'b0;
    n.hreadyout = 1'b1;

    // ----------------------------------------------------------------
    // Bus slave: read data is registered in the address phase.
    // ----------------------------------------------------------------
    n.a_v = hsel_i && hready_i && htrans_i[1];
    n.a_wr = hwrite_i;
    n.a_addr = haddr_i[7:0];
    case (haddr_i[7:0])
      `CFF_OFS_INSN: n.hrdata = {16'h0000, r.insn};
      `CFF_OFS_FLAGS: n.hrdata = {24'h000000, r.flags};
      `CFF_OFS_PC: n.hrdata = {16'h0000, r.pc};
      `CFF_OFS_SP: n.hrdata = {16'h0000, r.sp};
      `CFF_OFS_STATUS: n.hrdata = {29'h00000000, r.illegal, r.sleep, r.busy};
      `CFF_OFS_COUNT: n.hrdata = {24'h000000, r.cnt};
      `CFF_OFS_SRC: n.hrdata = {16'h0000, r.src};
      `CFF_OFS_DST: n.hrdata = {16'h0000, r.dst};
      `CFF_OFS_WORK: n.hrdata = {16'h0000, r.work};
      `CFF_OFS_OPND: n.hrdata = {16'h0000, r.opnd};
      default: n.hrdata = 32'h00000000;
    endcase
    if (!n.a_v || hwrite_i) begin
      n.hrdata = 32'h00000000;
    end
    if (r.a_v && r.a_wr && (r.st == cff_pkg::CFF_IDLE)) begin
      case (r.a_addr)
        `CFF_OFS_INSN: begin
          n.insn = hwdata_i[15:0];
          dop = op_decode(hwdata_i[15:0], bad);
          n.op = dop;
          n.illegal = bad;
          n.len = op_len(dop, r.cnt);
          n.step = 12'h000;
          n.st = cff_pkg::CFF_RUN;
          n.busy = 1'b1;
        end
        `CFF_OFS_FLAGS: n.flags = hwdata_i[7:0];
        `CFF_OFS_PC: n.pc = hwdata_i[15:0];
        `CFF_OFS_SP: n.sp = hwdata_i[15:0];
        `CFF_OFS_COUNT: n.cnt = hwdata_i[7:0];
        `CFF_OFS_SRC: n.src = hwdata_i[15:0];
        `CFF_OFS_DST: n.dst = hwdata_i[15:0];
        `CFF_OFS_WORK: n.work = hwdata_i[15:0];
        `CFF_OFS_OPND: n.opnd = hwdata_i[15:0];
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Execution: memory data returns two steps after the request step.
    // ----------------------------------------------------------------
    case (r.st)
      cff_pkg::CFF_RUN: begin
        last = (r.step == (r.len - 12'h001));
        n.step = r.step + 12'h001;
        case (r.op)
          cff_pkg::CFF_OP_CALL: begin
            case (r.step)
              12'h000: begin
                n.mem_req = 1'b1;
                n.mem_we = 1'b1;
                n.mem_addr = r.sp - 16'h0002;
                n.mem_wdata = r.pc[15:8];
              end
              12'h001: begin
                n.mem_req = 1'b1;
                n.mem_we = 1'b1;
                n.mem_addr = r.sp - 16'h0001;
                n.mem_wdata = r.pc[7:0];
                n.sp = r.sp - 16'h0002;
              end
              12'h002: begin
                n.mem_req = 1'b1;
                n.mem_addr = {8'h00, r.insn[7:0]};
              end
              12'h003: begin
                n.mem_req = 1'b1;
                n.mem_addr = {8'h00, r.insn[7:0] + 8'h01};
              end
              12'h004: n.hi = mem_rdata_i;
              12'h005: n.pc = {r.hi, mem_rdata_i};
              default: ;
            endcase
          end
          cff_pkg::CFF_OP_RTS: begin
            case (r.step)
              12'h000: begin
                n.mem_req = 1'b1;
                n.mem_addr = r.sp;
              end
              12'h001: begin
                n.mem_req = 1'b1;
                n.mem_addr = r.sp + 16'h0001;
              end
              12'h002: n.hi = mem_rdata_i;
              12'h003: begin
                n.pc = {r.hi, mem_rdata_i};
                n.sp = r.sp + 16'h0002;
              end
              default: ;
            endcase
          end
          cff_pkg::CFF_OP_XRET: begin
            case (r.step)
              12'h000: begin
                n.mem_req = 1'b1;
                n.mem_addr = r.sp;
              end
              12'h002: begin
                n.flags = mem_rdata_i;
                n.sp = r.sp + 16'h0002;
              end
              12'h003: begin
                n.mem_req = 1'b1;
                n.mem_addr = r.sp;
              end
              12'h004: begin
                n.mem_req = 1'b1;
                n.mem_addr = r.sp + 16'h0001;
              end
              12'h005: n.hi = mem_rdata_i;
              12'h006: begin
                n.pc = {r.hi, mem_rdata_i};
                n.sp = r.sp + 16'h0002;
              end
              default: ;
            endcase
          end
          cff_pkg::CFF_OP_BMOVE: begin
            if (r.cnt != 8'h00) begin
              case (r.step[1:0])
                2'b00: begin
                  n.mem_req = 1'b1;
                  n.mem_addr = r.src;
                end
                2'b10: begin
                  n.mem_req = 1'b1;
                  n.mem_we = 1'b1;
                  n.mem_addr = r.dst;
                  n.mem_wdata = mem_rdata_i;
                  n.src = r.src + 16'h0001;
                  n.dst = r.dst + 16'h0001;
                  n.cnt = r.cnt - 8'h01;
                end
                default: ;
              endcase
            end
          end
          default: begin
            if (last) begin
              case (r.op)
                cff_pkg::CFF_OP_LDCI: n.flags = r.insn[7:0];
                cff_pkg::CFF_OP_LDCR: n.flags = r.work[7:0];
                cff_pkg::CFF_OP_STC: n.work[7:0] = r.flags;
                cff_pkg::CFF_OP_ANDC: n.flags = r.flags & r.insn[7:0];
                cff_pkg::CFF_OP_ORC: n.flags = r.flags | r.insn[7:0];
                cff_pkg::CFF_OP_XORC: n.flags = r.flags ^ r.insn[7:0];
                cff_pkg::CFF_OP_ADDW: begin
                  n.work = sum17[15:0];
                  n.flags[`CFF_FL_H] = sum12[12];
                  n.flags[`CFF_FL_N] = sum17[15];
                  n.flags[`CFF_FL_Z] = (sum17[15:0] == 16'h0000);
                  n.flags[`CFF_FL_V] = (r.work[15] == r.opnd[15]) && (sum17[15] != r.work[15]);
                  n.flags[`CFF_FL_C] = sum17[16];
                end
                cff_pkg::CFF_OP_ADDX: begin
                  n.work[7:0] = sum9[7:0];
                  n.flags[`CFF_FL_H] = sum4[4];
                  n.flags[`CFF_FL_N] = sum9[7];
                  n.flags[`CFF_FL_Z] = (sum9[7:0] == 8'h00) ? r.flags[`CFF_FL_Z] : 1'b0;
                  n.flags[`CFF_FL_V] = (r.work[7] == r.opnd[7]) && (sum9[7] != r.work[7]);
                  n.flags[`CFF_FL_C] = sum9[8];
                end
                cff_pkg::CFF_OP_DEC_ADJ: begin
                  n.work[7:0] = daa9[7:0];
                  n.flags[`CFF_FL_N] = daa9[7];
                  n.flags[`CFF_FL_Z] = (daa9[7:0] == 8'h00);
                  n.flags[`CFF_FL_C] = daa9[8] | r.flags[`CFF_FL_C];
                end
                cff_pkg::CFF_OP_DIV: begin
                  n.work = {rem[7:0], quo[7:0]};
                  n.flags[`CFF_FL_N] = r.opnd[7];
                  n.flags[`CFF_FL_Z] = (r.opnd[7:0] == 8'h00);
                end
                default: ;
              endcase
            end
          end
        endcase
        if (last) begin
          n.busy = 1'b0;
          if (r.op == cff_pkg::CFF_OP_SLEEP) begin
            n.st = cff_pkg::CFF_SLEEP;
            n.sleep = 1'b1;
          end else begin
            n.st = cff_pkg::CFF_IDLE;
          end
        end
      end
      cff_pkg::CFF_SLEEP: begin
        if (wake_i) begin
          n.st = cff_pkg::CFF_IDLE;
          n.sleep = 1'b0;
        end
      end
      cff_pkg::CFF_IDLE: ;
      default: n.st = cff_pkg::CFF_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.st <= cff_pkg::CFF_IDLE;
      r.op <= cff_pkg::CFF_OP_NOP;
      r.flags <= `CFF_RST_FLAGS;
      r.pc <= `CFF_RST_WORD;
      r.sp <= `CFF_RST_WORD;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hrdata_o = r.hrdata;
  assign hreadyout_o = r.hreadyout;
  assign hresp_o = 1'b0;
  assign mem_req_o = r.mem_req;
  assign mem_we_o = r.mem_we;
  assign mem_addr_o = r.mem_addr;
  assign mem_wdata_o = r.mem_wdata;
  assign busy_o = r.busy;
  assign sleep_o = r.sleep;
endmodule : cff_exec
`default_nettype wire

// ### src/cff_consts.svh
// Constants for the flow-control and flag-operation execution unit.
// Summary of operation
// - The indirect call pushes the program counter below the stack pointer, loads it from the page-zero word and takes 8 states.
// - The return pops the program counter, adds two to the stack pointer, takes 8 states and keeps all flags.
// - The exception return pops the flag register, then the program counter, each with a two-byte pointer step, in 10 states.
// - The sleep instruction enters the low-power sleep state in 2 states and keeps all flags.
// - The block move copies bytes while the count is nonzero, stepping both pointers and the count, and skips a zero count.
// - The block move takes four states per byte plus nine, the byte count being the count at the start.
// - For word arithmetic the half-carry flag is the carry out of bit 11.
// - For extended arithmetic a zero result keeps the zero flag and a nonzero result clears it.
// - Decimal adjustment sets carry when the adjustment carries and otherwise keeps the prior carry.
// - The unsigned divide sets the negative flag from the sign of the divisor.
// - The unsigned divide sets the zero flag when the divisor is zero.
// - The operation is chosen from bits 15 to 8 of the first instruction word.
// - The block-move first byte is split by bit 7 of the first instruction word; with bit 7 set it is illegal.
// - Push and pop are decoded only as the move encodings they share.
`ifndef CFF_CONSTS_SVH
`define CFF_CONSTS_SVH
`define CFF_OFS_INSN 8'h00
`define CFF_OFS_FLAGS 8'h04
`define CFF_OFS_PC 8'h08
`define CFF_OFS_SP 8'h0c
`define CFF_OFS_STATUS 8'h10
`define CFF_OFS_COUNT 8'h14
`define CFF_OFS_SRC 8'h18
`define CFF_OFS_DST 8'h1c
`define CFF_OFS_WORK 8'h20
`define CFF_OFS_OPND 8'h24
`define CFF_RST_FLAGS 8'h80
`define CFF_RST_WORD 16'h0000
`define CFF_OPC_NOP 8'h00
`define CFF_OPC_SLEEP 8'h01
`define CFF_OPC_STC 8'h02
`define CFF_OPC_LDCR 8'h03
`define CFF_OPC_ORC 8'h04
`define CFF_OPC_XORC 8'h05
`define CFF_OPC_ANDC 8'h06
`define CFF_OPC_LDCI 8'h07
`define CFF_OPC_ADDW 8'h09
`define CFF_OPC_ADDX 8'h0e
`define CFF_OPC_DEC_ADJ 8'h0f
`define CFF_OPC_DIV 8'h51
`define CFF_OPC_RTS 8'h54
`define CFF_OPC_XRET 8'h56
`define CFF_OPC_CALL 8'h5f
`define CFF_OPC_MOVSTK 8'h6d
`define CFF_OPC_BMOVE 8'h7b
`define CFF_LEN_SHORT 12'h002
`define CFF_LEN_CALL 12'h008
`define CFF_LEN_RET 12'h008
`define CFF_LEN_XRET 12'h00a
`define CFF_MOVE_BASE 12'h009
`define CFF_FL_H 5
`define CFF_FL_N 3
`define CFF_FL_Z 2
`define CFF_FL_V 1
`define CFF_FL_C 0
`endif

// ### src/cff_pkg.sv
// Types of the flow-control and flag-operation execution unit.
package cff_pkg;
  typedef enum logic [1:0] {
    CFF_IDLE = 2'b00,
    CFF_RUN = 2'b01,
    CFF_SLEEP = 2'b11
  } cff_state_t;
  typedef enum logic [3:0] {
    CFF_OP_NOP, CFF_OP_SLEEP, CFF_OP_STC, CFF_OP_LDCR, CFF_OP_ORC, CFF_OP_XORC,
    CFF_OP_ANDC, CFF_OP_LDCI, CFF_OP_ADDW, CFF_OP_ADDX, CFF_OP_DEC_ADJ, CFF_OP_DIV,
    CFF_OP_RTS, CFF_OP_XRET, CFF_OP_CALL, CFF_OP_BMOVE
  } cff_op_t;
  typedef struct packed {
    cff_state_t st;
    cff_op_t op;
    logic [11:0] step;
    logic [11:0] len;
    logic [15:0] insn;
    logic [7:0] flags;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] cnt;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] work;
    logic [15:0] opnd;
    logic [7:0] hi;
    logic illegal;
    logic busy;
    logic sleep;
    logic a_v;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
  } cff_regs_t;
endpackage : cff_pkg

// ### dv/cff_mem.sv
// Byte-wide synchronous memory model on the far side of the execution unit.
`timescale 1ns/1ps
`default_nettype none
module cff_mem (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  initial begin
    rdata_o = 8'h00;
  end
  // A plain always process, since the bench preloads and inspects the array directly.
  always @(posedge clk_i) begin
    if (req_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
    // Read data stand one cycle; otherwise the line toggles so stale data cannot pass.
    rdata_o <= (req_i && !we_i) ? mem[addr_i] : ~rdata_o;
  end
endmodule : cff_mem
`default_nettype wire

// ### dv/cff_exec_monitor.sv
// Concurrent checks on the ports of the execution unit.
`timescale 1ns/1ps
`default_nettype none
module cff_exec_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic mem_req_o,
  input wire logic wake_i,
  input wire logic busy_o,
  input wire logic sleep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic rd_ph;
  logic [10:0] run;
  always_ff @(posedge clk_i) begin
    rd_ph <= resetn_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    run <= (!resetn_i || !busy_o) ? 11'h000 : run + 11'h001;
  end
  sequence insn_wr_s;
    hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == 8'h00 && !busy_o && !sleep_o;
  endsequence
  sequence run_s;
    busy_o [*2];
  endsequence
  zero_wait_a: assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1) else $error("bus answer not zero-wait");
  insn_start_a: assert property (insn_wr_s |-> ##2 run_s) else $error("instruction did not start");
  short_run_a: assert property ($rose(busy_o) |-> run_s) else $error("run shorter than two");
  busy_bound_a: assert property (run <= 11'd1029) else $error("run too long");
  rd_idle_a: assert property (!rd_ph |-> hrdata_o == 32'h0) else $error("read data outside data phase");
  mem_in_run_a: assert property (mem_req_o |-> busy_o) else $error("memory access while idle");
  sleep_quiet_a: assert property (sleep_o |-> !mem_req_o) else $error("memory access in sleep");
  wake_up_a: assert property (sleep_o && wake_i |=> !sleep_o) else $error("sleep not left");
  stay_asleep_a: assert property (sleep_o && !wake_i |=> sleep_o) else $error("sleep left early");
endmodule : cff_exec_monitor
bind cff_exec cff_exec_monitor cff_exec_monitor_i (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .mem_req_o(mem_req_o), .wake_i(wake_i), .busy_o(busy_o),
  .sleep_o(sleep_o));
`default_nettype wire

// ### dv/cff_exec_test.sv
// Self-checking bench for the flow-control and flag-operation unit.
`timescale 1ns/1ps
`default_nettype none
`include "cff_consts.svh"
module cff_exec_test;
  logic clk_i = 1'b0, resetn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, wake_i = 1'b0, dphase = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
  logic [1:0] htrans_i = 2'b00;
  logic [2:0] hsize_i = 3'b010;
  logic hreadyout_o, hresp_o, mem_req_o, mem_we_o, busy_o, sleep_o;
  logic [15:0] mem_addr_o, w;
  logic [7:0] mem_wdata_o, mem_rdata_i, f, d;
  logic [31:0] exp_q [$], msk_q [$];
  int errors = 0, num_checks = 0, n, c;
  cff_exec cff_exec_i (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .wake_i(wake_i),
    .busy_o(busy_o), .sleep_o(sleep_o));
  cff_mem cff_mem_i (.clk_i(clk_i), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .rdata_o(mem_rdata_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic results;
    $display("comparisons %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= dat;
    dphase <= !wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    dphase <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bus(1'b1, a, dat);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // The read result is compared at the edge that ends its data phase.
  always @(posedge clk_i) begin
    if (dphase === 1'b1) begin
      check(hrdata_o & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  task automatic exec(input logic [15:0] insn, input int len);
    wr(`CFF_OFS_INSN, {16'h0, insn});
    n = 0;
    #1;
    while (busy_o === 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    check(n, len);
    @(posedge clk_i);
  endtask : exec
  task automatic arith(input logic [7:0] op, input logic [15:0] wk, input logic [15:0] od, input logic [7:0] fi,
      input logic [15:0] we, input logic [7:0] fm, input logic [7:0] fe);
    wr(`CFF_OFS_FLAGS, {24'h0, fi});
    wr(`CFF_OFS_WORK, {16'h0, wk});
    wr(`CFF_OFS_OPND, {16'h0, od});
    exec({op, 8'h00}, 2);
    rd(`CFF_OFS_WORK, {16'h0, we});
    rd(`CFF_OFS_FLAGS, {24'h0, fe}, {24'h0, fm});
  endtask : arith
  initial begin
    #200000;
    errors++;
    results();
  end
  initial begin
    void'($urandom(32'h87db));
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(`CFF_OFS_FLAGS, 32'h80);
    for (int a = 8; a <= 'h3c; a += 4) begin
      rd(8'(a), 32'h0);
    end
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      f = 8'($urandom);
      wr(`CFF_OFS_FLAGS, {24'h0, f});
      exec({8'h04 + 8'(i), d}, 2);
      rd(`CFF_OFS_FLAGS, {24'h0, i == 0 ? f | d : i == 1 ? f ^ d : i == 2 ? f & d : d});
    end
    wr(`CFF_OFS_WORK, 32'h5a);
    exec(16'h0300, 2);
    wr(`CFF_OFS_WORK, 32'h0);
    exec(16'h0200, 2);
    rd(`CFF_OFS_WORK, 32'h5a);
    exec(16'h6d00, 2);
    rd(`CFF_OFS_STATUS, 32'h4);
    exec(16'h7b80, 2);
    rd(`CFF_OFS_STATUS, 32'h4);
    rd(`CFF_OFS_FLAGS, 32'h5a);
    $display("flag operations done");
    w = 16'($urandom);
    cff_mem_i.mem[16'h00aa] = w[15:8];
    cff_mem_i.mem[16'h00ab] = w[7:0];
    wr(`CFF_OFS_PC, 32'h1234);
    wr(`CFF_OFS_SP, 32'h0200);
    exec(16'h5faa, 8);
    rd(`CFF_OFS_PC, {16'h0, w});
    rd(`CFF_OFS_SP, 32'h01fe);
    check({24'h0, cff_mem_i.mem[16'h01fe]}, 32'h12);
    check({24'h0, cff_mem_i.mem[16'h01ff]}, 32'h34);
    exec(16'h5400, 8);
    rd(`CFF_OFS_PC, 32'h1234);
    rd(`CFF_OFS_SP, 32'h0200);
    rd(`CFF_OFS_FLAGS, 32'h5a);
    f = 8'($urandom);
    cff_mem_i.mem[16'h0200] = f;
    cff_mem_i.mem[16'h0202] = 8'hbe;
    cff_mem_i.mem[16'h0203] = 8'hef;
    exec(16'h5600, 10);
    rd(`CFF_OFS_FLAGS, {24'h0, f});
    rd(`CFF_OFS_PC, 32'hbeef);
    rd(`CFF_OFS_SP, 32'h0204);
    $display("calls and returns done");
    for (int k = 0; k < 3; k++) begin
      c = k == 2 ? 5 : k;
      for (int j = 0; j < c; j++) begin
        cff_mem_i.mem[16'h0300 + j] = 8'($urandom);
      end
      cff_mem_i.mem[16'h0400 + c] = 8'hee;
      wr(`CFF_OFS_COUNT, c);
      wr(`CFF_OFS_SRC, 32'h0300);
      wr(`CFF_OFS_DST, 32'h0400);
      exec(16'h7b5c, 4 * c + 9);
      for (int j = 0; j < c; j++) begin
        check({24'h0, cff_mem_i.mem[16'h0400 + j]}, {24'h0, cff_mem_i.mem[16'h0300 + j]});
      end
      check({24'h0, cff_mem_i.mem[16'h0400 + c]}, 32'hee);
      rd(`CFF_OFS_COUNT, 32'h0);
      rd(`CFF_OFS_SRC, 32'h0300 + c);
      rd(`CFF_OFS_DST, 32'h0400 + c);
    end
    $display("block move done");
    arith(8'h09, 16'h0f00, 16'h0100, 8'h00, 16'h1000, 8'hff, 8'h20);
    arith(8'h09, 16'h0700, 16'h0100, 8'h00, 16'h0800, 8'hff, 8'h00);
    arith(8'h0e, 16'h0000, 16'h0000, 8'h04, 16'h0000, 8'hff, 8'h04);
    arith(8'h0e, 16'h0001, 16'h0000, 8'h04, 16'h0001, 8'hff, 8'h00);
    arith(8'h0f, 16'h00a0, 16'h0000, 8'h00, 16'h0000, 8'h01, 8'h01);
    arith(8'h0f, 16'h0012, 16'h0000, 8'h00, 16'h0012, 8'h01, 8'h00);
    arith(8'h0f, 16'h0012, 16'h0000, 8'h01, 16'h0072, 8'h01, 8'h01);
    arith(8'h51, 16'h0017, 16'h0005, 8'h00, 16'h0304, 8'hff, 8'h00);
    arith(8'h51, 16'h0017, 16'h0085, 8'h00, 16'h1700, 8'hff, 8'h08);
    arith(8'h51, 16'h0017, 16'h0000, 8'h00, 16'h0017, 8'hff, 8'h04);
    $display("arithmetic flags done");
    wr(`CFF_OFS_FLAGS, 32'h5a);
    exec(16'h0100, 2);
    wr(`CFF_OFS_COUNT, 32'h33);
    rd(`CFF_OFS_COUNT, 32'h0);
    rd(`CFF_OFS_STATUS, 32'h2);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(`CFF_OFS_STATUS, 32'h0);
    rd(`CFF_OFS_FLAGS, 32'h5a);
    $display("sleep done");
    results();
  end
endmodule : cff_exec_test
`default_nettype wire
